// [logic/evt_ctr_pkg.sv]
// Package with register map, field positions and timing constants for the event counter channel
package evt_ctr_pkg;

   // ----------------------------------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------------------------------------
   localparam logic [7:0] CMD_OFS      = 8'h00;  // Command word
   localparam logic [7:0] STAT1_OFS    = 8'h04;  // First status word
   localparam logic [7:0] STAT2_OFS    = 8'h08;  // Second status word
   localparam logic [7:0] COUNT_OFS    = 8'h0c;  // Actual count value
   localparam logic [7:0] SP1_OFS      = 8'h10;  // First set point value
   localparam logic [7:0] SP2_OFS      = 8'h14;  // Second set point value
   localparam logic [7:0] FINAL_OFS    = 8'h18;  // Final set point value
   localparam logic [7:0] CFG_OFS      = 8'h1c;  // Direction, switch-off behaviour, set point type
   localparam logic [7:0] PULSE_OFS    = 8'h20;  // Output pulse time in milliseconds
   localparam logic [7:0] IRQ_STAT_OFS = 8'h24;  // Sticky event flags, read clears
   localparam logic [7:0] IRQ_MASK_OFS = 8'h28;  // Interrupt mask

   // ----------------------------------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------------------------------
   localparam int CMD_START_BIT  = 1;   // Start command bit D1
   localparam int CMD_SWOFF_BIT  = 2;   // Output switch-off command bit D2
   localparam int CMD_MODE_LSB   = 4;   // Operating mode field D7..D4
   localparam int STAT1_FINAL    = 11;  // Final set point status D11 of first word
   localparam int STAT2_FIRST    = 3;   // First set point status D3 of second word
   localparam int STAT2_SECOND   = 11;  // Second set point status D11 of second word
   localparam int IRQ_SP1        = 0;   // Event: first set point reached
   localparam int IRQ_SP2        = 1;   // Event: second set point reached
   localparam int IRQ_FINAL      = 2;   // Event: final set point reached
   localparam int IRQ_SWOFF      = 3;   // Event: outputs switched off

   // ----------------------------------------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------------------------------------
   localparam logic [15:0] CMD_RESET   = 16'h00a0;  // Mode field kept, no commands
   localparam logic [31:0] SP1_RESET   = 32'h0000_0005;
   localparam logic [31:0] SP2_RESET   = 32'h0000_000b;
   localparam logic [31:0] FINAL_RESET = 32'h0000_001e;
   localparam logic [15:0] PULSE_RESET = 16'h07d0;   // 2000 ms
   localparam int          CLK_MHZ     = 200;
   localparam int          MS_NS       = 1000000;    // One millisecond in ns
   localparam int          CLK_NS      = 1000 / CLK_MHZ;
   localparam int          MS_CYCLES   = MS_NS / CLK_NS;

   // ----------------------------------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------------------------------
   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic fin;
   } setpoint_out_s;

   typedef struct packed {
      logic count_enable_input;
      logic restart_permit_input;
      logic hw_switchoff_input;
      logic count_pulse;
   } field_in_s;

endpackage

// [logic/event_counter_output_control.sv]
// Event counter channel with set point outputs, switch-off and restart control behind AXI4-Lite
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1 - Before the final set point is reached a high hardware switch-off input turns off the four outputs.
// RULE2 - Software may switch the outputs off with command bit D2, writing 00a4 to keep the mode field.
// RULE3 - A switch-off drives every output low and clears final status D11 and set point statuses D3 and D11.
// RULE4 - A restart is only accepted once an output switch-off has happened; earlier requests are ignored.
// RULE5 - Restart needs the final value not yet reached and the restart permit input high.
// RULE6 - The restart fires on a rising edge of start command bit D1, which software must produce.
// RULE7 - A counter reset sets the count to zero and re-arms the set point outputs.
// RULE8 - A change of mode, direction, switch-off behaviour or set point type while outputs are on drops them.
// RULE9 - The second set point status falls when the count reaches the second set point, eleven by default.
// RULE10 - The final set point status falls when the count reaches the final value, thirty by default.
// RULE11 - Counting only happens while the count enable input is held high by the field.
// RULE12 - Reaching a set point switches its output on for the pulse time, two seconds by default.
// RULE13 - The count steps once per qualified input pulse while enabled and not switched off; the code stops counting at the final value.
module event_counter_output_control
(
   input  wire logic                         sys_clk_i,
   input  wire logic                         rst_n_i,
   input  wire evt_ctr_pkg::field_in_s       field_i,
   output evt_ctr_pkg::setpoint_out_s        setpoint_o,
   output logic                              irq_o,
   input  wire logic [7:0]                   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [7:0]                   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready
);
   import evt_ctr_pkg::*;

   // ----------------------------------------------------------------------------------------------
   // Field input synchronisers
   // ----------------------------------------------------------------------------------------------
   logic [3:0] sync1, sync2, sync3, clean;
   logic [3:0] next_clean;

   // Stage one is read only by stage two; a change counts when stages two and three agree
   always_comb
   begin
      next_clean = clean;
      for (int i = 0; i < 4; i++)
      begin
         if (sync2[i] == sync3[i])
            next_clean[i] = sync3[i];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
         clean <= 4'h0;
      end
      else
      begin
         sync1 <= field_i;
         sync2 <= sync1;
         sync3 <= sync2;
         clean <= next_clean;
      end
   end

   field_in_s fin;
   logic      pulse_d;
   assign fin = field_in_s'(clean);

   // ----------------------------------------------------------------------------------------------
   // Register bus slave
   // ----------------------------------------------------------------------------------------------
   logic        aw_held, w_held, bvalid, rvalid;
   logic [7:0]  aw_addr;
   logic [31:0] w_data, rdata;
   logic [1:0]  bresp, rresp;
   logic [15:0] cmd;
   logic [31:0] sp1, sp2, fin_sp;
   logic [2:0]  cfg;
   logic [15:0] pulse_ms;
   logic [3:0]  irq_stat, irq_mask;
   logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
   logic [7:0]  next_aw_addr;
   logic [31:0] next_w_data, next_rdata;
   logic [1:0]  next_bresp, next_rresp;
   logic [15:0] next_cmd, next_pulse_ms;
   logic [31:0] next_sp1, next_sp2, next_fin_sp;
   logic [2:0]  next_cfg;
   logic [3:0]  next_irq_mask;
   logic        wr_go, rd_go, stat_rd;

   // Byte-lane merge onto zero used for every writable word; unstrobed lanes are written as zero
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            old[i*8 +: 8] = nw[i*8 +: 8];
      end
      return old;
   endfunction

   assign s_axi_awready = !aw_held && !bvalid;
   assign s_axi_wready  = !w_held && !bvalid;
   assign s_axi_arready = !rvalid;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rdata   = rdata;
   assign s_axi_rresp   = rresp;
   assign wr_go   = aw_held && w_held && !bvalid;
   assign rd_go   = s_axi_arvalid && !rvalid;
   assign stat_rd = rd_go && (s_axi_araddr == IRQ_STAT_OFS);

   logic [15:0] stat1, stat2;
   logic [31:0] count;

   // Address and data may arrive in either order; the response follows once both are held
   always_comb
   begin
      next_aw_held  = aw_held;
      next_w_held   = w_held;
      next_aw_addr  = aw_addr;
      next_w_data   = w_data;
      next_bvalid   = bvalid;
      next_bresp    = bresp;
      next_rvalid   = rvalid;
      next_rdata    = rdata;
      next_rresp    = rresp;
      next_cmd      = cmd;
      next_sp1      = sp1;
      next_sp2      = sp2;
      next_fin_sp   = fin_sp;
      next_cfg      = cfg;
      next_pulse_ms = pulse_ms;
      next_irq_mask = irq_mask;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_data = merge(32'h0, s_axi_wdata, s_axi_wstrb);
      end
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (wr_go)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = 2'b00;
         if (aw_addr == CMD_OFS)
            next_cmd = w_data[15:0];            // RULE2
         else if (aw_addr == SP1_OFS)
            next_sp1 = w_data;
         else if (aw_addr == SP2_OFS)
            next_sp2 = w_data;
         else if (aw_addr == FINAL_OFS)
            next_fin_sp = w_data;
         else if (aw_addr == CFG_OFS)
            next_cfg = w_data[2:0];
         else if (aw_addr == PULSE_OFS)
            next_pulse_ms = w_data[15:0];
         else if (aw_addr == IRQ_MASK_OFS)
            next_irq_mask = w_data[3:0];
         else if (aw_addr != STAT1_OFS && aw_addr != STAT2_OFS && aw_addr != COUNT_OFS
                  && aw_addr != IRQ_STAT_OFS)
            next_bresp = 2'b10;                 // Unmapped address
      end
      if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      if (rd_go)
      begin
         next_rvalid = 1'b1;
         next_rresp  = 2'b00;
         next_rdata  = 32'h0;
         if (s_axi_araddr == CMD_OFS)
            next_rdata = {16'h0, cmd};
         else if (s_axi_araddr == STAT1_OFS)
            next_rdata = {16'h0, stat1};
         else if (s_axi_araddr == STAT2_OFS)
            next_rdata = {16'h0, stat2};
         else if (s_axi_araddr == COUNT_OFS)
            next_rdata = count;
         else if (s_axi_araddr == SP1_OFS)
            next_rdata = sp1;
         else if (s_axi_araddr == SP2_OFS)
            next_rdata = sp2;
         else if (s_axi_araddr == FINAL_OFS)
            next_rdata = fin_sp;
         else if (s_axi_araddr == CFG_OFS)
            next_rdata = {29'h0, cfg};
         else if (s_axi_araddr == PULSE_OFS)
            next_rdata = {16'h0, pulse_ms};
         else if (s_axi_araddr == IRQ_STAT_OFS)
            next_rdata = {28'h0, irq_stat};
         else if (s_axi_araddr == IRQ_MASK_OFS)
            next_rdata = {28'h0, irq_mask};
         else
            next_rresp = 2'b10;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         aw_held  <= 1'b0;
         w_held   <= 1'b0;
         aw_addr  <= 8'h00;
         w_data   <= 32'h0;
         bvalid   <= 1'b0;
         bresp    <= 2'b00;
         rvalid   <= 1'b0;
         rdata    <= 32'h0;
         rresp    <= 2'b00;
         cmd      <= CMD_RESET;
         sp1      <= SP1_RESET;
         sp2      <= SP2_RESET;
         fin_sp   <= FINAL_RESET;
         cfg      <= 3'h0;
         pulse_ms <= PULSE_RESET;
         irq_mask <= 4'h0;
      end
      else
      begin
         aw_held  <= next_aw_held;
         w_held   <= next_w_held;
         aw_addr  <= next_aw_addr;
         w_data   <= next_w_data;
         bvalid   <= next_bvalid;
         bresp    <= next_bresp;
         rvalid   <= next_rvalid;
         rdata    <= next_rdata;
         rresp    <= next_rresp;
         cmd      <= next_cmd;
         sp1      <= next_sp1;
         sp2      <= next_sp2;
         fin_sp   <= next_fin_sp;
         cfg      <= next_cfg;
         pulse_ms <= next_pulse_ms;
         irq_mask <= next_irq_mask;
      end
   end

   // ----------------------------------------------------------------------------------------------
   // Counter, set point and switch-off core
   // ----------------------------------------------------------------------------------------------
   logic        armed, switched_off, start_d;
   logic [6:0]  cfg_d;
   logic [3:0]  outs;
   logic [15:0] ms_left [4];
   logic [17:0] ms_div;
   logic [31:0] next_count;
   logic        next_armed, next_switched_off;
   logic [3:0]  next_outs, next_irq_stat, evt;
   logic [15:0] next_ms_left [4];
   logic [17:0] next_ms_div;
   logic        ms_tick, final_hit, start_rise, cfg_chg, do_off, do_restart;
   logic [31:0] sp_val [4];

   assign sp_val[0]  = sp1;
   assign sp_val[1]  = sp2;
   assign sp_val[2]  = fin_sp;
   assign sp_val[3]  = fin_sp;
   assign ms_tick    = (ms_div == 18'(MS_CYCLES - 1));
   assign final_hit  = (count >= fin_sp);
   assign start_rise = cmd[CMD_START_BIT] && !start_d;                              // RULE6
   assign cfg_chg    = ({cmd[CMD_MODE_LSB +: 4], cfg} != cfg_d) && (outs != 4'h0);    // RULE8
   assign do_off     = !final_hit && armed
                       && (fin.hw_switchoff_input || cmd[CMD_SWOFF_BIT]);              // RULE1 RULE2
   assign do_restart = switched_off && start_rise && !final_hit
                       && fin.restart_permit_input;                                     // RULE4 RULE5

   // Status words: set point bits high while armed and not yet reached
   assign stat1 = 16'((armed && count < fin_sp) ? (1 << STAT1_FINAL) : 0);             // RULE3 RULE10
   assign stat2 = 16'(((armed && count < sp1) ? (1 << STAT2_FIRST) : 0)
                      | ((armed && count < sp2) ? (1 << STAT2_SECOND) : 0));           // RULE3 RULE9
   assign setpoint_o = setpoint_out_s'({outs[0], outs[1], outs[2], outs[3]});  // Index 0 drives output a
   assign irq_o      = |(irq_stat & irq_mask);

   // Next count, timers and sticky events; sets win over the read clear
   always_comb
   begin
      next_count        = count;
      next_armed        = armed;
      next_switched_off = switched_off;
      next_outs         = outs;
      next_ms_div       = ms_tick ? 18'h0 : ms_div + 18'h1;
      evt               = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         next_ms_left[i] = ms_left[i];
         if (outs[i] && ms_tick)
         begin
            if (ms_left[i] == 16'h0)
               next_outs[i] = 1'b0;                      // RULE12
            else
               next_ms_left[i] = ms_left[i] - 16'h1;
         end
      end
      if (do_off)
      begin
         next_outs         = 4'h0;                        // RULE3
         next_armed        = 1'b0;
         next_switched_off = 1'b1;
         evt[IRQ_SWOFF]    = 1'b1;
      end
      else if (do_restart)
      begin
         next_count        = 32'h0;                       // RULE7
         next_armed        = 1'b1;
         next_switched_off = 1'b0;
      end
      else if (cfg_chg)
         next_outs = 4'h0;                               // RULE8
      else if (fin.count_enable_input && fin.count_pulse && !pulse_d
               && armed && !final_hit)                    // RULE11 RULE13
      begin
         next_count = count + 32'h1;
         for (int i = 0; i < 4; i++)
         begin
            if (count + 32'h1 == sp_val[i])
            begin
               next_outs[i]    = 1'b1;                    // RULE12
               next_ms_left[i] = pulse_ms;
            end
         end
         evt[2:0] = next_outs[2:0] & ~outs[2:0];
      end
      next_irq_stat = (stat_rd ? 4'h0 : irq_stat) | evt;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         count        <= 32'h0;
         armed        <= 1'b1;
         switched_off <= 1'b0;
         outs         <= 4'h0;
         ms_div       <= 18'h0;
         irq_stat     <= 4'h0;
         start_d      <= 1'b0;
         pulse_d      <= 1'b0;
         cfg_d        <= {CMD_RESET[CMD_MODE_LSB +: 4], 3'h0};  // Matches reset settings, no false change
         for (int i = 0; i < 4; i++)
            ms_left[i] <= 16'h0;
      end
      else
      begin
         count        <= next_count;
         armed        <= next_armed;
         switched_off <= next_switched_off;
         outs         <= next_outs;
         ms_div       <= next_ms_div;
         irq_stat     <= next_irq_stat;
         start_d      <= cmd[CMD_START_BIT];
         pulse_d      <= fin.count_pulse;
         cfg_d        <= {cmd[CMD_MODE_LSB +: 4], cfg};
         ms_left      <= next_ms_left;
      end
   end

   // ----------------------------------------------------------------------------------------------
   // Checks on switch-off, restart, reconfiguration and counting
   // ----------------------------------------------------------------------------------------------
   chk_hw_off_drops : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE1
      fin.hw_switchoff_input && armed && !final_hit |=> (outs == 4'h0))
      else $error("hardware switch-off left an output on");
   chk_off_clears_all : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE3
      do_off |=> (outs == 4'h0 && stat1 == 16'h0 && stat2 == 16'h0))
      else $error("switch-off left an output or status bit set");
   chk_restart_after_off : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE4
      $rose(armed) |-> $past(switched_off))
      else $error("re-armed without a prior switch-off");
   chk_restart_permit : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE5
      $rose(armed) |-> ($past(fin.restart_permit_input) && !$past(final_hit)))
      else $error("restart taken without permit or after final value");
   chk_restart_zero : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE7
      do_restart |=> (count == 32'h0 && armed))
      else $error("restart did not clear the count");
   chk_cfg_drops_outs : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE8
      cfg_chg && !do_restart |=> (outs == 4'h0))
      else $error("configuration change left an output on");
   chk_count_single_step : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE13
      (count != $past(count)) && (count != 32'h0) |-> (count == $past(count) + 32'h1))
      else $error("count moved by more than one step");

endmodule // event_counter_output_control

// [test/field_model.sv]
// Field side model: discrete levels and counter input pulses with random spacing
`timescale 1ns/1ps
module field_model
(
   input  wire logic                sys_clk_i,
   input  wire logic                enable_i,
   input  wire logic                permit_i,
   input  wire logic                hw_off_i,
   input  wire logic                go_i,
   input  wire logic [7:0]          count_i,
   output evt_ctr_pkg::field_in_s   field_o,
   output logic                     busy_o
);
   import evt_ctr_pkg::*;
   logic pulse = 1'b0;
   int   seed  = 38274;
   int   gap;
   // --------------------------------------------------------------
   // Levels pass straight through, the pulse comes from below
   // --------------------------------------------------------------
   assign field_o = {enable_i, permit_i, hw_off_i, pulse};
   // Each pulse is held 4 cycles so the three-flop sync sees it
   initial
   begin
      busy_o = 1'b0;
      forever
      begin
         @(posedge sys_clk_i);
         if (go_i && count_i != 8'h00)
         begin
            busy_o <= 1'b1;
            for (int i = 0; i < count_i; i++)
            begin
               gap = 4 + int'($unsigned($random(seed)) % 8);
               pulse <= 1'b1;
               repeat (4) @(posedge sys_clk_i);
               pulse <= 1'b0;
               repeat (gap) @(posedge sys_clk_i);
            end
            busy_o <= 1'b0;
         end
      end
   end
endmodule  // field_model

// [test/event_counter_output_control_tb_top.sv]
// Testbench for the event counter output and restart control channel
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module event_counter_output_control_tb_top;
   import evt_ctr_pkg::*;
   logic          sys_clk = 1'b0;
   logic          rst_n   = 1'b0;
   logic [7:0]    awaddr  = 8'h00;
   logic [7:0]    araddr  = 8'h00;
   logic [31:0]   wdata   = 32'h0;
   logic          awvalid = 1'b0;
   logic          wvalid  = 1'b0;
   logic          bready  = 1'b0;
   logic          arvalid = 1'b0;
   logic          rready  = 1'b0;
   logic          en      = 1'b0;
   logic          permit  = 1'b0;
   logic          hwoff   = 1'b0;
   logic          go      = 1'b0;
   logic [7:0]    npulse  = 8'h00;
   logic          awready, wready, bvalid, arready, rvalid, irq, busy;
   logic [1:0]    bresp, rresp;
   logic [31:0]   rdata;
   field_in_s     fld;
   setpoint_out_s sp;
   logic [33:0]   exp_q[$];
   logic [33:0]   e;
   int            n_fail     = 0;
   int            num_checks = 0;
   // --------------------------------------------------------------
   // Clock, design and field model
   // --------------------------------------------------------------
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   event_counter_output_control uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .field_i(fld), .setpoint_o(sp),
      .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   field_model fm (.sys_clk_i(sys_clk), .enable_i(en), .permit_i(permit), .hw_off_i(hwoff), .go_i(go),
      .count_i(npulse), .field_o(fld), .busy_o(busy));
   // --------------------------------------------------------------
   // Bus tasks; each ends one edge after the answer
   // --------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      `CHK("bresp", er, bresp)
      bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Expected read result is queued before the request goes out
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      exp_q.push_back({er, d});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Ask the field model for n pulses and let the sync settle
   task automatic pulses(input logic [7:0] n);
      int t;
      npulse <= n;
      go     <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      for (t = 0; t < 2000; t++)
      begin
         @(posedge sys_clk);
         if (!busy) break;
      end
      repeat (8) @(posedge sys_clk);
   endtask
   // Read answers are matched against the oldest note; for an error answer only the response is compared, not its zero data
   always @(posedge sys_clk)
   begin
      if (rvalid && rready)
      begin
         e = exp_q.pop_front();
         if (e[33:32] !== 2'b00) `CHK("rresp", e[33:32], rresp)
         else `CHK("rdata", e, {rresp, rdata})
      end
   end
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // About a thousand cycles are expected; the limit leaves wide margin
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      report_and_stop();
   end
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(CMD_OFS, 32'h00a0);
      rd(STAT1_OFS, 32'h0800);
      rd(STAT2_OFS, 32'h0808);
      rd(COUNT_OFS, 32'h0);
      rd(SP1_OFS, 32'h5);
      rd(SP2_OFS, 32'hb);
      rd(FINAL_OFS, 32'h1e);
      rd(PULSE_OFS, 32'h7d0);
      rd(IRQ_MASK_OFS, 32'h0);
      rd(8'h2c, 32'h0, 2'b10);
      wr(8'h2c, 32'h1, 2'b10);
      wr(PULSE_OFS, 32'h1);
      en <= 1'b1;
      pulses(5);
      rd(COUNT_OFS, 32'h5);
      `CHK("setpoint", 4'b1000, sp)
      rd(STAT2_OFS, 32'h0800);
      `CHK("irq masked", 1'b0, irq)
      wr(IRQ_MASK_OFS, 32'hf);
      repeat (2) @(posedge sys_clk);
      `CHK("irq", 1'b1, irq)
      rd(IRQ_STAT_OFS, 32'h1);
      repeat (2) @(posedge sys_clk);
      `CHK("irq cleared", 1'b0, irq)
      pulses(6);
      rd(COUNT_OFS, 32'hb);
      rd(STAT2_OFS, 32'h0);
      `CHK("setpoint", 4'b1100, sp)
      permit <= 1'b1;
      wr(CMD_OFS, 32'h00a2);
      rd(COUNT_OFS, 32'hb);
      wr(CMD_OFS, 32'h00a0);
      wr(CMD_OFS, 32'h00a4);
      repeat (2) @(posedge sys_clk);
      `CHK("setpoint", 4'b0000, sp)
      rd(STAT1_OFS, 32'h0);
      rd(STAT2_OFS, 32'h0);
      pulses(2);
      rd(COUNT_OFS, 32'hb);
      wr(CMD_OFS, 32'h00a0);
      permit <= 1'b0;
      repeat (8) @(posedge sys_clk);
      wr(CMD_OFS, 32'h00a2);
      rd(COUNT_OFS, 32'hb);
      wr(CMD_OFS, 32'h00a0);
      permit <= 1'b1;
      repeat (8) @(posedge sys_clk);
      wr(CMD_OFS, 32'h00a2);
      rd(COUNT_OFS, 32'h0);
      rd(STAT1_OFS, 32'h0800);
      rd(STAT2_OFS, 32'h0808);
      pulses(5);
      `CHK("setpoint", 4'b1000, sp)
      hwoff <= 1'b1;
      pulses(0);
      `CHK("setpoint", 4'b0000, sp)
      rd(STAT2_OFS, 32'h0);
      hwoff <= 1'b0;
      pulses(0);
      wr(CMD_OFS, 32'h00a0);
      wr(CMD_OFS, 32'h00a2);
      rd(COUNT_OFS, 32'h0);
      pulses(5);
      `CHK("setpoint", 4'b1000, sp)
      wr(CFG_OFS, 32'h1);
      repeat (2) @(posedge sys_clk);
      `CHK("setpoint", 4'b0000, sp)
      pulses(27);
      rd(COUNT_OFS, 32'h1e);
      rd(STAT1_OFS, 32'h0);
      `CHK("setpoint", 4'b0111, sp)
      repeat (4) @(posedge sys_clk);
      report_and_stop();
   end
endmodule  // event_counter_output_control_tb_top
